// ### design/mdl_decoder.sv
// decode and execution timing for multiply, divide, decimal adjust,
// sign extension, shift/rotate and and/or/test instructions
// assumes opcode bytes arrive one per handshake from the prefetch side
// What this block does
// RL1: 1111011w, middle 101: signed product, 25-28/34-37/31-34/40-43.
// RL2: 011010s1: signed product by immediate, one or two bytes, 22-25/29-32.
// RL3: 1111011w, middle 110: unsigned quotient, 29/38/35/44 cycles.
// RL4: 1111011w, middle 111: signed quotient, 44-52/53-61/50-58/59-67.
// RL5: bytes 11010100 then 00001010: product decimal adjust, 19 cycles.
// RL6: bytes 11010101 then 00001010: dividend decimal adjust, 15 cycles.
// RL7: byte 10011000 extends low accumulator byte to word in 2 cycles.
// RL8: byte 10011001 extends accumulator word to a pair in 4 cycles.
// RL9: 1101000w shifts or rotates by one, 2 register or 15 memory cycles.
// RL10: 1101001w shifts by count register low byte, 5+n or 17+n cycles.
// RL11: 1100000w shifts by an immediate count byte, 5+n or 17+n cycles.
// RL12: middle field picks the shift or rotate operation, 110 unused.
// RL13: and forms 001000dw, 1000000w/100, 0010010w with their cycle counts.
// RL14: or forms 000010dw, 1000000w/001, 0000110w timed like the and forms.
// RL15: test is an and that sets flags only, three forms and timings.
// RL16: immediate data is one byte, plus a second byte when w is one.
// RL17: narrow bus variant adds 4 cycles per memory transfer of a word.
// RL18: low opcode bit selects byte or word; d bit selects register dest.

`timescale 1ns/1ps

module mdl_decoder
  import mdl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction byte stream
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  output logic byteReady,
  // core state
  input wire logic [7:0] shiftCountRegLow,
  input wire logic narrowBus,
  // decoded operation
  output logic opValid,
  output mdl_kind_t opKind,
  output mdl_logic_t logicFn,
  output mdl_shift_t shiftOp,
  output logic opIsWord,
  output logic opIsMem,
  output logic regIsDest,
  output logic storesResult,
  output logic [1:0] modField,
  output logic [2:0] regField,
  output logic [2:0] rmField,
  output logic [15:0] dispData,
  output logic [15:0] immData,
  output logic [7:0] shiftCount,
  output mdl_cyc_t cycMin,
  output mdl_cyc_t cycMax,
  // sequencing
  output logic foreignOp,
  output logic busy,
  output logic execDone
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] dispBytes(input logic [7:0] mrm);
    logic [1:0] nb;
    nb = 2'd0;
    if (mrm[7:6] == MOD_DISP8)
      nb = 2'd1;
    else if (mrm[7:6] == MOD_DISP16)
      nb = 2'd2;
    else if (mrm[7:6] == 2'd0 && mrm[2:0] == RM_DIRECT)
      nb = 2'd2;
    return nb;
  endfunction : dispBytes

  // returns {min, max}; data-dependent ranges keep both ends
  function automatic logic [2*CYC_W-1:0] cycRange(
    input mdl_kind_t k,
    input mdl_logic_t f,
    input logic w,
    input logic mem,
    input logic toReg,
    input logic [7:0] n,
    input logic narrow
  );
    mdl_cyc_t lo;
    mdl_cyc_t hi;
    mdl_cyc_t nc;
    logic [1:0] xfers;
    mdl_cyc_t extra;
    nc = CYC_W'(n);
    lo = BYTE_TO_WORD_CYC;
    hi = BYTE_TO_WORD_CYC;
    xfers = 2'd0;
    unique case (k)
      K_SIGNED_PRODUCT:
      begin
        lo = mem ? (w ? SPROD_MW_MIN : SPROD_MB_MIN)
                 : (w ? SPROD_RW_MIN : SPROD_RB_MIN); // RL1
        hi = mem ? (w ? SPROD_MW_MAX : SPROD_MB_MAX)
                 : (w ? SPROD_RW_MAX : SPROD_RB_MAX); // RL1
        xfers = 2'd1;
      end
      K_UNSIGNED_QUOTIENT:
      begin
        lo = mem ? (w ? UQUO_MW : UQUO_MB) : (w ? UQUO_RW : UQUO_RB); // RL3
        hi = lo;
        xfers = 2'd1;
      end
      K_SIGNED_QUOTIENT:
      begin
        lo = mem ? (w ? SQUO_MW_MIN : SQUO_MB_MIN)
                 : (w ? SQUO_RW_MIN : SQUO_RB_MIN); // RL4
        hi = mem ? (w ? SQUO_MW_MAX : SQUO_MB_MAX)
                 : (w ? SQUO_RW_MAX : SQUO_RB_MAX); // RL4
        xfers = 2'd1;
      end
      K_SIGNED_PRODUCT_IMM:
      begin
        lo = mem ? SPIMM_M_MIN : SPIMM_R_MIN; // RL2
        hi = mem ? SPIMM_M_MAX : SPIMM_R_MAX; // RL2
        xfers = 2'd1;
      end
      K_BCD_PRODUCT_ADJUST:
      begin
        lo = BCD_PRODUCT_CYC; // RL5
        hi = lo;
      end
      K_BCD_DIVIDEND_ADJUST:
      begin
        lo = BCD_DIVIDEND_CYC; // RL6
        hi = lo;
      end
      K_BYTE_TO_WORD_EXTEND:
      begin
        lo = BYTE_TO_WORD_CYC; // RL7
        hi = lo;
      end
      K_WORD_TO_PAIR_EXTEND:
      begin
        lo = WORD_TO_PAIR_CYC; // RL8
        hi = lo;
      end
      K_SHIFT_ONE:
      begin
        lo = mem ? SHIFT1_M : SHIFT1_R; // RL9
        hi = lo;
        xfers = 2'd2;
      end
      K_SHIFT_BY_REG, K_SHIFT_BY_IMM:
      begin
        lo = (mem ? SHIFTN_M_BASE : SHIFTN_R_BASE) + nc; // RL10 RL11
        hi = lo;
        xfers = 2'd2;
      end
      K_LOGIC_RM_REG:
      begin
        lo = mem ? LOGIC_RM_M : LOGIC_RM_R; // RL13 RL14 RL15
        hi = lo;
        xfers = (f == LOGIC_TEST || toReg) ? 2'd1 : 2'd2;
      end
      K_LOGIC_IMM_RM:
      begin
        if (f == LOGIC_TEST)
          lo = mem ? TEST_IMM_M : TEST_IMM_R; // RL15
        else
          lo = mem ? LOGIC_IMM_M : LOGIC_IMM_R; // RL13 RL14
        hi = lo;
        xfers = (f == LOGIC_TEST) ? 2'd1 : 2'd2;
      end
      K_LOGIC_IMM_ACC:
      begin
        lo = w ? LOGIC_ACC_W : LOGIC_ACC_B; // RL13 RL14 RL15
        hi = lo;
      end
      default:
      begin
        lo = BYTE_TO_WORD_CYC;
        hi = BYTE_TO_WORD_CYC;
      end
    endcase
    // on the narrow bus each memory transfer of a word costs a second byte cycle
    extra = (narrow && w && mem) ?
            NARROW_XFER_CYC * CYC_W'(xfers) : '0; // RL17
    return {lo + extra, hi + extra};
  endfunction : cycRange

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mdl_state_t state_r, state_nxt;
  mdl_kind_t kind_r, kind_nxt;
  mdl_logic_t logic_r, logic_nxt;
  mdl_shift_t shift_r, shift_nxt;
  logic [7:0] opc_r, opc_nxt;
  logic [7:0] modrm_r, modrm_nxt;
  logic word_r, word_nxt;
  logic mem_r, mem_nxt;
  logic toReg_r, toReg_nxt;
  logic stores_r, stores_nxt;
  logic sext_r, sext_nxt;
  logic first_r, first_nxt;
  logic [1:0] dispLeft_r, dispLeft_nxt;
  logic [1:0] immLeft_r, immLeft_nxt;
  logic [15:0] disp_r, disp_nxt;
  logic [15:0] imm_r, imm_nxt;
  logic [7:0] count_r, count_nxt;
  mdl_cyc_t cycMin_r, cycMin_nxt;
  mdl_cyc_t cycMax_r, cycMax_nxt;
  mdl_cyc_t cnt_r, cnt_nxt;
  logic opValid_r, opValid_nxt;
  logic foreign_r, foreign_nxt;
  logic done_r, done_nxt;

  logic take;
  logic advance;
  logic finish;
  logic [7:0] nNow;
  logic [2*CYC_W-1:0] range;

  assign byteReady = (state_r != ST_EXEC);
  assign take = byteValid && byteReady;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    logic_nxt = logic_r;
    shift_nxt = shift_r;
    opc_nxt = opc_r;
    modrm_nxt = modrm_r;
    word_nxt = word_r;
    mem_nxt = mem_r;
    toReg_nxt = toReg_r;
    stores_nxt = stores_r;
    sext_nxt = sext_r;
    first_nxt = first_r;
    dispLeft_nxt = dispLeft_r;
    immLeft_nxt = immLeft_r;
    disp_nxt = disp_r;
    imm_nxt = imm_r;
    count_nxt = count_r;
    cycMin_nxt = cycMin_r;
    cycMax_nxt = cycMax_r;
    cnt_nxt = cnt_r;
    opValid_nxt = 1'b0;
    foreign_nxt = 1'b0;
    done_nxt = 1'b0;
    advance = 1'b0;
    finish = 1'b0;
    nNow = 8'h01;
    range = '0;
    unique case (state_r)
      ST_OPC:
      if (take)
      begin
        opc_nxt = byteData;
        word_nxt = byteData[0]; // RL18
        toReg_nxt = 1'b0;
        stores_nxt = 1'b1;
        mem_nxt = 1'b0;
        sext_nxt = 1'b0;
        first_nxt = 1'b1;
        modrm_nxt = {MOD_REG, 6'h00};
        dispLeft_nxt = 2'd0;
        immLeft_nxt = 2'd0;
        disp_nxt = 16'h0000;
        imm_nxt = 16'h0000;
        state_nxt = ST_MODRM;
        if (byteData[7:2] == PAT_PROD_IMM && byteData[0])
        begin
          kind_nxt = K_SIGNED_PRODUCT_IMM; // RL2
          word_nxt = 1'b1;
          toReg_nxt = 1'b1;
          sext_nxt = byteData[1];
          immLeft_nxt = byteData[1] ? 2'd1 : 2'd2; // RL2
        end
        else if (byteData == OPC_BCD_PRODUCT)
        begin
          kind_nxt = K_BCD_PRODUCT_ADJUST; // RL5
          state_nxt = ST_ADJ2;
        end
        else if (byteData == OPC_BCD_DIVIDEND)
        begin
          kind_nxt = K_BCD_DIVIDEND_ADJUST; // RL6
          state_nxt = ST_ADJ2;
        end
        else if (byteData == OPC_BYTE_TO_WORD)
        begin
          kind_nxt = K_BYTE_TO_WORD_EXTEND; // RL7
          finish = 1'b1;
        end
        else if (byteData == OPC_WORD_TO_PAIR)
        begin
          kind_nxt = K_WORD_TO_PAIR_EXTEND; // RL8
          word_nxt = 1'b1;
          finish = 1'b1;
        end
        else if (byteData[7:1] == PAT_AND_ACC ||
                 byteData[7:1] == PAT_OR_ACC ||
                 byteData[7:1] == PAT_TEST_ACC)
        begin
          kind_nxt = K_LOGIC_IMM_ACC; // RL13 RL14 RL15
          logic_nxt = (byteData[7:1] == PAT_AND_ACC) ? LOGIC_AND :
                      (byteData[7:1] == PAT_OR_ACC) ? LOGIC_OR : LOGIC_TEST;
          stores_nxt = (byteData[7:1] != PAT_TEST_ACC); // RL15
          toReg_nxt = 1'b1;
          immLeft_nxt = byteData[0] ? 2'd2 : 2'd1; // RL16
          state_nxt = ST_IMM;
        end
        else if (byteData[7:1] == PAT_UNARY ||
                 byteData[7:1] == PAT_SHIFT_ONE ||
                 byteData[7:1] == PAT_SHIFT_REG ||
                 byteData[7:1] == PAT_SHIFT_IMM ||
                 byteData[7:1] == PAT_IMM_GROUP ||
                 byteData[7:1] == PAT_TEST_RM ||
                 byteData[7:2] == PAT_AND_RM ||
                 byteData[7:2] == PAT_OR_RM)
          state_nxt = ST_MODRM;
        else
        begin
          // not in this group; the fetch side hands it elsewhere
          foreign_nxt = 1'b1;
          state_nxt = ST_OPC;
        end
      end
      ST_MODRM:
      if (take)
      begin
        modrm_nxt = byteData;
        mem_nxt = (byteData[7:6] != MOD_REG);
        dispLeft_nxt = dispBytes(byteData);
        advance = 1'b1;
        if (opc_r[7:1] == PAT_UNARY)
        begin
          unique case (byteData[5:3])
            MID_SPROD: kind_nxt = K_SIGNED_PRODUCT; // RL1
            MID_UQUO: kind_nxt = K_UNSIGNED_QUOTIENT; // RL3
            MID_SQUO: kind_nxt = K_SIGNED_QUOTIENT; // RL4
            MID_TEST:
            begin
              kind_nxt = K_LOGIC_IMM_RM; // RL15
              logic_nxt = LOGIC_TEST;
              stores_nxt = 1'b0;
              immLeft_nxt = opc_r[0] ? 2'd2 : 2'd1; // RL16
            end
            default: advance = 1'b0;
          endcase
        end
        else if (opc_r[7:1] == PAT_IMM_GROUP)
        begin
          kind_nxt = K_LOGIC_IMM_RM;
          logic_nxt = (byteData[5:3] == MID_AND) ? LOGIC_AND : LOGIC_OR;
          immLeft_nxt = opc_r[0] ? 2'd2 : 2'd1; // RL16
          advance = (byteData[5:3] == MID_AND ||
                     byteData[5:3] == MID_OR); // RL13 RL14
        end
        else if (opc_r[7:1] == PAT_TEST_RM)
        begin
          kind_nxt = K_LOGIC_RM_REG;
          logic_nxt = LOGIC_TEST;
          stores_nxt = 1'b0; // RL15
        end
        else if (opc_r[7:2] == PAT_AND_RM || opc_r[7:2] == PAT_OR_RM)
        begin
          kind_nxt = K_LOGIC_RM_REG;
          logic_nxt = (opc_r[7:2] == PAT_AND_RM) ? LOGIC_AND : LOGIC_OR;
          toReg_nxt = opc_r[1]; // RL18
        end
        else if (opc_r[7:2] == PAT_PROD_IMM)
          advance = 1'b1;
        else
        begin
          shift_nxt = mdl_shift_t'(byteData[5:3]); // RL12
          advance = (byteData[5:3] != MID_SHIFT_BAD); // RL12
          if (opc_r[7:1] == PAT_SHIFT_ONE)
            kind_nxt = K_SHIFT_ONE; // RL9
          else if (opc_r[7:1] == PAT_SHIFT_REG)
            kind_nxt = K_SHIFT_BY_REG; // RL10
          else
          begin
            kind_nxt = K_SHIFT_BY_IMM; // RL11
            immLeft_nxt = 2'd1;
          end
        end
        if (!advance)
        begin
          foreign_nxt = 1'b1;
          state_nxt = ST_OPC;
        end
      end
      ST_ADJ2:
      if (take)
      begin
        if (byteData == OPC_ADJ_SECOND)
          finish = 1'b1; // RL5 RL6
        else
        begin
          foreign_nxt = 1'b1;
          state_nxt = ST_OPC;
        end
      end
      ST_DISP:
      if (take)
      begin
        if (first_r)
          disp_nxt = {{8{byteData[7]}}, byteData};
        else
          disp_nxt = {byteData, disp_r[7:0]};
        first_nxt = (dispLeft_r == 2'd2) ? 1'b0 : 1'b1;
        dispLeft_nxt = dispLeft_r - 2'd1;
        advance = 1'b1;
      end
      ST_IMM:
      if (take)
      begin
        if (first_r)
          imm_nxt = {sext_r ? {8{byteData[7]}} : 8'h00, byteData};
        else
          imm_nxt = {byteData, imm_r[7:0]}; // RL16
        first_nxt = 1'b0;
        immLeft_nxt = immLeft_r - 2'd1;
        advance = 1'b1;
      end
      ST_EXEC:
      begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == mdl_cyc_t'(1))
        begin
          done_nxt = 1'b1;
          state_nxt = ST_OPC;
        end
      end
      default: state_nxt = ST_OPC;
    endcase

    // operand bytes come in the order displacement, then immediate
    if (advance)
    begin
      if (dispLeft_nxt != 2'd0)
        state_nxt = ST_DISP;
      else if (immLeft_nxt != 2'd0)
        state_nxt = ST_IMM;
      else
        finish = 1'b1;
    end

    if (finish)
    begin
      if (kind_nxt == K_SHIFT_BY_REG)
        nNow = shiftCountRegLow; // RL10
      else if (kind_nxt == K_SHIFT_BY_IMM)
        nNow = imm_nxt[7:0]; // RL11
      range = cycRange(kind_nxt, logic_nxt, word_nxt, mem_nxt, toReg_nxt,
                       nNow, narrowBus);
      cycMin_nxt = range[2*CYC_W-1:CYC_W];
      cycMax_nxt = range[CYC_W-1:0];
      // timer runs to the worst case so the slot is never cut short
      cnt_nxt = range[CYC_W-1:0] - 1'b1;
      count_nxt = nNow;
      opValid_nxt = 1'b1;
      state_nxt = ST_EXEC;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_OPC;
      kind_r <= K_BYTE_TO_WORD_EXTEND;
      logic_r <= LOGIC_AND;
      shift_r <= SH_ROTATE_LEFT;
      opc_r <= 8'h00;
      modrm_r <= 8'h00;
      word_r <= 1'b0;
      mem_r <= 1'b0;
      toReg_r <= 1'b0;
      stores_r <= 1'b0;
      sext_r <= 1'b0;
      first_r <= 1'b0;
      dispLeft_r <= 2'd0;
      immLeft_r <= 2'd0;
      disp_r <= 16'h0000;
      imm_r <= 16'h0000;
      count_r <= 8'h00;
      cycMin_r <= '0;
      cycMax_r <= '0;
      cnt_r <= '0;
      opValid_r <= 1'b0;
      foreign_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      logic_r <= logic_nxt;
      shift_r <= shift_nxt;
      opc_r <= opc_nxt;
      modrm_r <= modrm_nxt;
      word_r <= word_nxt;
      mem_r <= mem_nxt;
      toReg_r <= toReg_nxt;
      stores_r <= stores_nxt;
      sext_r <= sext_nxt;
      first_r <= first_nxt;
      dispLeft_r <= dispLeft_nxt;
      immLeft_r <= immLeft_nxt;
      disp_r <= disp_nxt;
      imm_r <= imm_nxt;
      count_r <= count_nxt;
      cycMin_r <= cycMin_nxt;
      cycMax_r <= cycMax_nxt;
      cnt_r <= cnt_nxt;
      opValid_r <= opValid_nxt;
      foreign_r <= foreign_nxt;
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign opValid = opValid_r;
  assign opKind = kind_r;
  assign logicFn = logic_r;
  assign shiftOp = shift_r;
  assign opIsWord = word_r;
  assign opIsMem = mem_r;
  assign regIsDest = toReg_r;
  assign storesResult = stores_r;
  assign modField = modrm_r[7:6];
  assign regField = modrm_r[5:3];
  assign rmField = modrm_r[2:0];
  assign dispData = disp_r;
  assign immData = imm_r;
  assign shiftCount = count_r;
  assign cycMin = cycMin_r;
  assign cycMax = cycMax_r;
  assign foreignOp = foreign_r;
  assign busy = (state_r == ST_EXEC);
  assign execDone = done_r;

endmodule : mdl_decoder

// ### design/mdl_pkg.sv
// constants, encodings and cycle figures for the multiply/divide/logic
// decoder; assumes an 8-bit opcode stream delivered in program order
package mdl_pkg;

  // ----------------------------------------------------------------
  // widths and encodings
  // ----------------------------------------------------------------
  localparam int CYC_W = 10;
  typedef logic [CYC_W-1:0] mdl_cyc_t;

  typedef enum logic [2:0] {
    ST_OPC = 3'b000,
    ST_MODRM = 3'b001,
    ST_ADJ2 = 3'b010,
    ST_DISP = 3'b011,
    ST_IMM = 3'b100,
    ST_EXEC = 3'b101
  } mdl_state_t;

  typedef enum logic [3:0] {
    K_SIGNED_PRODUCT = 4'h0,
    K_UNSIGNED_QUOTIENT = 4'h1,
    K_SIGNED_QUOTIENT = 4'h2,
    K_SIGNED_PRODUCT_IMM = 4'h3,
    K_BCD_PRODUCT_ADJUST = 4'h4,
    K_BCD_DIVIDEND_ADJUST = 4'h5,
    K_BYTE_TO_WORD_EXTEND = 4'h6,
    K_WORD_TO_PAIR_EXTEND = 4'h7,
    K_SHIFT_ONE = 4'h8,
    K_SHIFT_BY_REG = 4'h9,
    K_SHIFT_BY_IMM = 4'ha,
    K_LOGIC_RM_REG = 4'hb,
    K_LOGIC_IMM_RM = 4'hc,
    K_LOGIC_IMM_ACC = 4'hd
  } mdl_kind_t;

  typedef enum logic [1:0] {
    LOGIC_AND = 2'h0,
    LOGIC_OR = 2'h1,
    LOGIC_TEST = 2'h2
  } mdl_logic_t;

  typedef enum logic [2:0] {
    SH_ROTATE_LEFT = 3'h0,
    SH_ROTATE_RIGHT = 3'h1,
    SH_ROTATE_CARRY_LEFT = 3'h2,
    SH_ROTATE_CARRY_RIGHT = 3'h3,
    SH_SHIFT_LEFT = 3'h4,
    SH_LOGICAL_SHIFT_RIGHT = 3'h5,
    SH_ARITH_SHIFT_RIGHT = 3'h7
  } mdl_shift_t;

  // ----------------------------------------------------------------
  // opcode patterns (upper bits, low bits are w or d,w)
  // ----------------------------------------------------------------
  localparam logic [6:0] PAT_UNARY = 7'h7b;
  localparam logic [5:0] PAT_PROD_IMM = 6'h1a;
  localparam logic [7:0] OPC_BCD_PRODUCT = 8'hd4;
  localparam logic [7:0] OPC_BCD_DIVIDEND = 8'hd5;
  localparam logic [7:0] OPC_ADJ_SECOND = 8'h0a;
  localparam logic [7:0] OPC_BYTE_TO_WORD = 8'h98;
  localparam logic [7:0] OPC_WORD_TO_PAIR = 8'h99;
  localparam logic [6:0] PAT_SHIFT_ONE = 7'h68;
  localparam logic [6:0] PAT_SHIFT_REG = 7'h69;
  localparam logic [6:0] PAT_SHIFT_IMM = 7'h60;
  localparam logic [5:0] PAT_AND_RM = 6'h08;
  localparam logic [5:0] PAT_OR_RM = 6'h02;
  localparam logic [6:0] PAT_TEST_RM = 7'h42;
  localparam logic [6:0] PAT_IMM_GROUP = 7'h40;
  localparam logic [6:0] PAT_AND_ACC = 7'h12;
  localparam logic [6:0] PAT_OR_ACC = 7'h06;
  localparam logic [6:0] PAT_TEST_ACC = 7'h54;

  localparam logic [2:0] MID_TEST = 3'h0;
  localparam logic [2:0] MID_OR = 3'h1;
  localparam logic [2:0] MID_AND = 3'h4;
  localparam logic [2:0] MID_SPROD = 3'h5;
  localparam logic [2:0] MID_UQUO = 3'h6;
  localparam logic [2:0] MID_SQUO = 3'h7;
  localparam logic [2:0] MID_SHIFT_BAD = 3'h6;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [2:0] RM_DIRECT = 3'h6;

  // ----------------------------------------------------------------
  // execution cycle figures (core clocks)
  // ----------------------------------------------------------------
  localparam mdl_cyc_t SPROD_RB_MIN = 10'd25, SPROD_RB_MAX = 10'd28;
  localparam mdl_cyc_t SPROD_RW_MIN = 10'd34, SPROD_RW_MAX = 10'd37;
  localparam mdl_cyc_t SPROD_MB_MIN = 10'd31, SPROD_MB_MAX = 10'd34;
  localparam mdl_cyc_t SPROD_MW_MIN = 10'd40, SPROD_MW_MAX = 10'd43;
  localparam mdl_cyc_t UQUO_RB = 10'd29, UQUO_RW = 10'd38;
  localparam mdl_cyc_t UQUO_MB = 10'd35, UQUO_MW = 10'd44;
  localparam mdl_cyc_t SQUO_RB_MIN = 10'd44, SQUO_RB_MAX = 10'd52;
  localparam mdl_cyc_t SQUO_RW_MIN = 10'd53, SQUO_RW_MAX = 10'd61;
  localparam mdl_cyc_t SQUO_MB_MIN = 10'd50, SQUO_MB_MAX = 10'd58;
  localparam mdl_cyc_t SQUO_MW_MIN = 10'd59, SQUO_MW_MAX = 10'd67;
  localparam mdl_cyc_t SPIMM_R_MIN = 10'd22, SPIMM_R_MAX = 10'd25;
  localparam mdl_cyc_t SPIMM_M_MIN = 10'd29, SPIMM_M_MAX = 10'd32;
  localparam mdl_cyc_t BCD_PRODUCT_CYC = 10'd19;
  localparam mdl_cyc_t BCD_DIVIDEND_CYC = 10'd15;
  localparam mdl_cyc_t BYTE_TO_WORD_CYC = 10'd2;
  localparam mdl_cyc_t WORD_TO_PAIR_CYC = 10'd4;
  localparam mdl_cyc_t SHIFT1_R = 10'd2, SHIFT1_M = 10'd15;
  localparam mdl_cyc_t SHIFTN_R_BASE = 10'd5, SHIFTN_M_BASE = 10'd17;
  localparam mdl_cyc_t LOGIC_RM_R = 10'd3, LOGIC_RM_M = 10'd10;
  localparam mdl_cyc_t LOGIC_IMM_R = 10'd4, LOGIC_IMM_M = 10'd16;
  localparam mdl_cyc_t TEST_IMM_R = 10'd4, TEST_IMM_M = 10'd10;
  localparam mdl_cyc_t LOGIC_ACC_B = 10'd3, LOGIC_ACC_W = 10'd4;
  localparam mdl_cyc_t NARROW_XFER_CYC = 10'd4;

endpackage : mdl_pkg

// ### verif/mdl_decoder_asserts.sv
// checks on decode handshake and cycle figures of the decoder
// assumes binding onto mdl_decoder, one clock and reset rst_n
`timescale 1ns/1ps
module mdl_decoder_asserts
  import mdl_pkg::*;
(
  // clock, reset and watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic narrowBus,
  input wire logic byteReady,
  input wire logic opValid,
  input wire mdl_kind_t opKind,
  input wire logic opIsWord,
  input wire logic opIsMem,
  input wire mdl_cyc_t cycMax,
  input wire logic busy,
  input wire logic execDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  done_slot_a: assert property (execDone |-> byteReady && $past(busy))
    else $error("done without busy slot");
  busy_hold_a: assert property (opValid |-> busy ##1 (busy || execDone))
    else $error("busy dropped early");
  byte_ext_a: assert property (opValid
    && opKind == K_BYTE_TO_WORD_EXTEND |-> cycMax == 10'd2 ##1 execDone)
    else $error("byte extend timing");
  pair_ext_a: assert property (opValid
    && opKind == K_WORD_TO_PAIR_EXTEND |-> cycMax == 10'd4 ##3 execDone)
    else $error("pair extend timing");
  prod_adj_a: assert property (opValid && opKind == K_BCD_PRODUCT_ADJUST
    |-> cycMax == 10'd19 ##18 execDone) else $error("product adjust timing");
  div_adj_a: assert property (opValid && opKind == K_BCD_DIVIDEND_ADJUST
    |-> cycMax == 10'd15 ##14 execDone) else $error("dividend adjust timing");
  quo_cyc_a: assert property (opValid && opKind == K_UNSIGNED_QUOTIENT
    |-> cycMax == (opIsMem ? (opIsWord ? 10'd44 : 10'd35)
    : (opIsWord ? 10'd38 : 10'd29)) + (narrowBus && opIsWord && opIsMem
    ? 10'd4 : 10'd0)) else $error("quotient timing");
  shift_one_a: assert property (opValid && opKind == K_SHIFT_ONE
    |-> cycMax == (opIsMem ? 10'd15 : 10'd2) + (narrowBus && opIsWord
    && opIsMem ? 10'd8 : 10'd0)) else $error("shift timing");
  cover property (opValid && opKind == K_SIGNED_QUOTIENT);
  cover property (opValid && narrowBus && opIsMem);
  cover property (opValid && opKind == K_SHIFT_ONE);
endmodule : mdl_decoder_asserts
bind mdl_decoder mdl_decoder_asserts u_mdl_decoder_asserts (.*);

// ### verif/mdl_decoder_test.sv
// scenario bench for the decoder, one task per pair or group of instruction families, plus one for foreign bytes
// assumes mdl_pkg and the bound checker are compiled before it
`timescale 1ns/1ps
module mdl_decoder_test
  import mdl_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, byteValid = 1'b0, narrowBus = 1'b0;
  logic [7:0] byteData = 8'h00, shiftCountRegLow = 8'h00, shiftCount;
  logic byteReady, opValid, opIsWord, opIsMem, regIsDest, storesResult;
  logic foreignOp, busy, execDone;
  logic [1:0] modField;
  logic [2:0] regField, rmField;
  logic [15:0] dispData, immData;
  mdl_kind_t opKind;
  mdl_logic_t logicFn;
  mdl_shift_t shiftOp;
  mdl_cyc_t cycMin, cycMax;
  int fails = 0, checked = 0, ticks = 0;
  mdl_decoder u_mdl_decoder (.*);
  initial forever #2.5 clk = ~clk;
  task automatic chk(input string what, input logic [15:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic op(input int n, input logic [31:0] b, input mdl_kind_t k,
    input mdl_cyc_t cyc);
    int i;
    for (i = 0; i < n; i++)
    begin
      byteValid = 1'b1;
      byteData = b[8*i+:8];
      @(negedge clk);
    end
    byteValid = 1'b0;
    chk("opValid", 16'h0001, opValid);
    chk("opKind", k, opKind);
    chk("cycMax", cyc, cycMax);
    chk("busy", 16'h0001, busy);
    chk("byteReady", 16'h0000, byteReady);
    for (i = 0; execDone !== 1'b1 && i < 200; i++)
      @(negedge clk);
    chk("doneAt", cyc - 10'd1, i[15:0]);
    chk("readyAtDone", 16'h0001, byteReady);
  endtask : op
  task automatic t_simple();
    op(1, 8'h98, K_BYTE_TO_WORD_EXTEND, 10'd2);
    op(1, 8'h99, K_WORD_TO_PAIR_EXTEND, 10'd4);
    op(2, 16'h0ad4, K_BCD_PRODUCT_ADJUST, 10'd19);
    op(2, 16'h0ad5, K_BCD_DIVIDEND_ADJUST, 10'd15);
    $display("extend and adjust done");
  endtask : t_simple
  task automatic t_muldiv();
    op(2, 16'he8f6, K_SIGNED_PRODUCT, 10'd28);
    op(4, 32'h20002ef6, K_SIGNED_PRODUCT, 10'd34);
    chk("cycMin", 16'h001f, cycMin);
    op(2, 16'hf0f6, K_UNSIGNED_QUOTIENT, 10'd29);
    op(2, 16'hf8f7, K_SIGNED_QUOTIENT, 10'd61);
    chk("cycMin", 16'h0035, cycMin);
    narrowBus = 1'b1;
    op(4, 32'h123436f7, K_UNSIGNED_QUOTIENT, 10'd48);
    chk("dispData", 16'h1234, dispData);
    chk("modrm", 16'h0036, {modField, regField, rmField});
    chk("memWord", 16'h0003, {opIsMem, opIsWord});
    narrowBus = 1'b0;
    op(3, 24'h80c06b, K_SIGNED_PRODUCT_IMM, 10'd25);
    chk("immData", 16'hff80, immData);
    op(4, 32'h1234c069, K_SIGNED_PRODUCT_IMM, 10'd25);
    chk("immData", 16'h1234, immData);
    $display("multiply and divide done");
  endtask : t_muldiv
  task automatic t_shift();
    int j;
    for (j = 0; j < 8; j++)
      if (j != 6)
      begin
        op(2, {16'h0, 2'h3, j[2:0], 3'h0, 8'hd0}, K_SHIFT_ONE, 10'd2);
        chk("shiftOp", j[15:0], shiftOp);
      end
    shiftCountRegLow = 8'h03;
    op(2, 16'he0d2, K_SHIFT_BY_REG, 10'd8);
    chk("shiftCount", 16'h0003, shiftCount);
    op(3, 24'h05f8c0, K_SHIFT_BY_IMM, 10'd10);
    $display("shift and rotate done");
  endtask : t_shift
  task automatic t_logic();
    op(3, 24'h123425, K_LOGIC_IMM_ACC, 10'd4);
    chk("immData", 16'h1234, immData);
    op(2, 16'h55a8, K_LOGIC_IMM_ACC, 10'd3);
    chk("stores", 16'h0000, storesResult);
    op(4, 32'h078046f6, K_LOGIC_IMM_RM, 10'd10);
    chk("dispData", 16'hff80, dispData);
    narrowBus = 1'b1;
    op(4, 32'h10000621, K_LOGIC_RM_REG, 10'd18);
    chk("regIsDest", 16'h0000, regIsDest);
    narrowBus = 1'b0;
    op(4, 32'h0001c881, K_LOGIC_IMM_RM, 10'd4);
    chk("logicFn", LOGIC_OR, logicFn);
    op(2, 16'hd80a, K_LOGIC_RM_REG, 10'd3);
    chk("regIsDest", 16'h0001, regIsDest);
    $display("logic forms done");
  endtask : t_logic
  task automatic t_foreign();
    int i;
    for (i = 0; i < 3; i++)
    begin
      byteValid = 1'b1;
      byteData = (i == 0) ? 8'h90 : (i == 1) ? 8'hf6 : 8'hd0;
      @(negedge clk);
      if (i != 1)
      begin
        chk("foreignOp", 16'h0001, foreignOp);
        chk("opValid", 16'h0000, opValid);
      end
    end
    byteValid = 1'b0;
    @(negedge clk);
    chk("foreignOp", 16'h0000, foreignOp);
    $display("foreign bytes done");
  endtask : t_foreign
  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // all scenarios fit well inside this many cycles
  always @(posedge clk)
    if (++ticks == 4000)
    begin
      fails++;
      summarize();
    end
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_simple();
    t_muldiv();
    t_shift();
    t_logic();
    t_foreign();
    summarize();
  end
endmodule : mdl_decoder_test
